// *** core/isr_exec_pkg.sv ***
package isr_exec_pkg;

    // ==========================================================
    // widths
    // ==========================================================
    localparam int PTR_W  = 16;
    localparam int DATA_W = 8;
    localparam int PC_W   = 15;
    localparam int OFS_W  = 6;
    localparam int INSN_W = 14;

    // ==========================================================
    // instruction encodings (14-bit words)
    // ==========================================================
    localparam logic [13:0] OP_NOP        = 14'h0000;
    localparam logic [13:0] OP_RETURN     = 14'h0008;
    localparam logic [13:0] OP_RETURN_FROM_IRQ     = 14'h0009;
    localparam logic [13:0] OP_OPTION     = 14'h0062;
    localparam logic [13:0] OP_RESET      = 14'h0001;
    localparam logic [10:0] OP_STORE_MASK = 11'h003;  // insn[13:3] of mode form
    localparam logic [6:0]  OP_STORE_REL  = 7'h3F;    // insn[13:7] of offset form

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int MODE_LSB  = 0;
    localparam int SEL_MODE  = 2;
    localparam int SEL_REL   = 6;
    localparam int OFS_LSB   = 0;
    localparam int GIE_BIT   = 7;

    // ==========================================================
    // pointer modes
    // ==========================================================
    localparam logic [1:0] MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;

    // ==========================================================
    // reset values and timing
    // ==========================================================
    localparam logic [15:0] PTR_RST    = 16'h0000;
    localparam logic [7:0]  OPTION_RST = 8'hFF;
    localparam logic [14:0] PC_RST     = 15'h0000;
    localparam int          RET_CYCLES = 2;

    typedef enum logic [1:0] {
        PH_EXEC,
        PH_FLUSH
    } phase_e;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_s;

endpackage

// *** core/pointer_bank.sv ***
// two file-select pointers, both read out directly from the registers; rd_sel is unused
module pointer_bank #(
    parameter int PTR_W = 16
) (
    input  wire logic             clk,      // core clock
    input  wire logic             rst,      // async reset
    input  wire logic             rd_sel,   // pointer to read, unused inside
    input  wire logic             wr_en,    // write strobe
    input  wire logic             wr_sel,   // pointer to write
    input  wire logic [PTR_W-1:0] wr_data,  // new pointer value
    output logic      [PTR_W-1:0] ptr0,     // pointer 0
    output logic      [PTR_W-1:0] ptr1      // pointer 1
);

    logic [PTR_W-1:0] mem_q [2];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (wr_en) begin
            mem_q[wr_sel] <= wr_data;
        end
    end

    assign ptr0 = mem_q[0];
    assign ptr1 = mem_q[1];

    wire unused_sel = rd_sel;

endmodule

// *** core/indirect_store_and_return_exec.sv ***
// Operation
// - store W at address in selected pointer
// - mode codes 00 preinc 01 predec 10 postinc
// - pre modes address pointer plus/minus one
// - pointer after store: +1, -1, or unchanged
// - offset form addresses pointer plus signed offset
// - pointer sixteen bits, wraps around
// - store and pointer update touch no flags
// - option load copies W, flags untouched
// - reset instruction resets device, clears flag
// - irq return pops stack, sets enable
// - irq return one word, two cycles
// - subroutine return pops, two cycles, nothing else
module indirect_store_and_return_exec #(
    parameter int PTR_W = isr_exec_pkg::PTR_W,
    parameter int PC_W  = isr_exec_pkg::PC_W
) (
    input  wire logic                                  MCLK,          // core clock
    input  wire logic                                  SYS_RST,       // async reset, high
    input  wire logic [isr_exec_pkg::INSN_W-1:0]       INSN,          // instruction word
    input  wire logic                                  INSN_VALID,    // word present
    input  wire logic [isr_exec_pkg::DATA_W-1:0]       W_REG,         // working register
    input  wire logic [PC_W-1:0]                       STACK_TOP,     // top stack entry
    output logic      [PC_W-1:0]                       PROGRAM_COUNTER, // program counter
    output logic                                       STACK_POP,     // pop strobe
    output logic                                       GLOBAL_IRQ_ENABLE, // irq enable bit
    output logic      [isr_exec_pkg::DATA_W-1:0]       OPTION_REG,    // option register
    output logic                                       RESET_INSTR_FLAG_N, // low after sw reset
    output logic                                       SW_RESET_REQ,  // device reset pulse
    output isr_exec_pkg::mem_wr_s                      MEM_WR,        // data memory write
    output logic      [PTR_W-1:0]                      PTR0,          // pointer 0
    output logic      [PTR_W-1:0]                      PTR1,          // pointer 1
    output logic                                       BUSY           // second cycle of return
);

    // ==========================================================
    // decode
    // ==========================================================
    function automatic logic is_op(input logic [13:0] w, input logic [13:0] op);
        return w == op;
    endfunction

    isr_exec_pkg::phase_e phase_q, phase_d;

    wire       exec     = INSN_VALID && (phase_q == isr_exec_pkg::PH_EXEC);
    wire       st_mode  = exec && (INSN[13:3] == isr_exec_pkg::OP_STORE_MASK);
    wire       st_rel   = exec && (INSN[13:7] == isr_exec_pkg::OP_STORE_REL);
    wire       do_nop   = exec && is_op(INSN, isr_exec_pkg::OP_NOP);
    wire       do_ret   = exec && is_op(INSN, isr_exec_pkg::OP_RETURN);
    wire       do_rfi   = exec && is_op(INSN, isr_exec_pkg::OP_RETURN_FROM_IRQ);
    wire       do_opt   = exec && is_op(INSN, isr_exec_pkg::OP_OPTION);
    wire       do_rst   = exec && is_op(INSN, isr_exec_pkg::OP_RESET);
    wire       do_pop   = do_ret || do_rfi;
    wire [1:0] mode     = INSN[isr_exec_pkg::MODE_LSB +: 2];
    wire       sel      = st_rel ? INSN[isr_exec_pkg::SEL_REL] : INSN[isr_exec_pkg::SEL_MODE];

    // ==========================================================
    // pointer arithmetic
    // ==========================================================
    logic [PTR_W-1:0] ptr0_w, ptr1_w;
    wire  [PTR_W-1:0] cur     = sel ? ptr1_w : ptr0_w;
    wire  [PTR_W-1:0] inc     = PTR_W'(cur + 1'b1);
    wire  [PTR_W-1:0] dec     = PTR_W'(cur - 1'b1);
    wire  [PTR_W-1:0] ofs     = PTR_W'($signed(INSN[isr_exec_pkg::OFS_LSB +: isr_exec_pkg::OFS_W]));
    wire  [PTR_W-1:0] rel     = PTR_W'(cur + ofs);
    wire              is_inc  = (mode == isr_exec_pkg::MODE_PRE_INC) || (mode == isr_exec_pkg::MODE_POST_INC);
    wire  [PTR_W-1:0] upd     = is_inc ? inc : dec;
    wire  [PTR_W-1:0] st_addr = st_rel ? rel :
                                (mode == isr_exec_pkg::MODE_PRE_INC) ? inc :
                                (mode == isr_exec_pkg::MODE_PRE_DEC) ? dec : cur;
    wire              ptr_we  = st_mode;

    pointer_bank #(
        .PTR_W (PTR_W)
    ) u_ptrs (
        .clk     (MCLK),
        .rst     (SYS_RST),
        .rd_sel  (sel),
        .wr_en   (ptr_we),
        .wr_sel  (sel),
        .wr_data (upd),
        .ptr0    (ptr0_w),
        .ptr1    (ptr1_w)
    );

    // ==========================================================
    // program counter and phase
    // ==========================================================
    wire [PC_W-1:0] pc_step = PC_W'(PROGRAM_COUNTER + 1'b1);
    wire [PC_W-1:0] pc_next = do_pop ? STACK_TOP :
                              exec   ? pc_step :
                              PROGRAM_COUNTER;

    always_comb begin
        phase_d = isr_exec_pkg::PH_EXEC;
        if (do_pop) begin
            phase_d = isr_exec_pkg::PH_FLUSH;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            phase_q <= isr_exec_pkg::PH_EXEC;
        end else begin
            phase_q <= phase_d;
        end
    end

    // counter holds during the flush cycle of a return
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PROGRAM_COUNTER <= isr_exec_pkg::PC_RST;
        end else begin
            PROGRAM_COUNTER <= pc_next;
        end
    end

    // ==========================================================
    // return pulses
    // ==========================================================
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            STACK_POP <= 1'b0;
        end else begin
            STACK_POP <= do_pop;
        end
    end

    // word offered while this is high is dropped
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= do_pop;
        end
    end

    // ==========================================================
    // control registers; flags never touched here
    // ==========================================================
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            GLOBAL_IRQ_ENABLE <= 1'b0;
        end else begin
            if (do_rfi) begin
                GLOBAL_IRQ_ENABLE <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            OPTION_REG <= isr_exec_pkg::OPTION_RST;
        end else begin
            if (do_opt) begin
                OPTION_REG <= W_REG;
            end
        end
    end

    // ==========================================================
    // software reset
    // ==========================================================
    // flag survives SYS_RST so software can see the cause
    always_ff @(posedge MCLK) begin
        if (do_rst) begin
            RESET_INSTR_FLAG_N <= 1'b0;
        end else if (RESET_INSTR_FLAG_N !== 1'b0) begin
            RESET_INSTR_FLAG_N <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SW_RESET_REQ <= 1'b0;
        end else begin
            SW_RESET_REQ <= do_rst;
        end
    end

    // ==========================================================
    // data memory write
    // ==========================================================
    wire st_any = st_mode || st_rel;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEM_WR <= '0;
        end else begin
            MEM_WR.we   <= st_any;
            MEM_WR.addr <= st_addr;
            MEM_WR.data <= W_REG;
        end
    end

    // ==========================================================
    // pointer copies
    // ==========================================================
    // copies load the same value as the bank, on the same edge
    wire [PTR_W-1:0] ptr0_next = (ptr_we && !sel) ? upd : ptr0_w;
    wire [PTR_W-1:0] ptr1_next = (ptr_we && sel) ? upd : ptr1_w;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PTR0 <= isr_exec_pkg::PTR_RST;
        end else begin
            PTR0 <= ptr0_next;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PTR1 <= isr_exec_pkg::PTR_RST;
        end else begin
            PTR1 <= ptr1_next;
        end
    end

endmodule

// *** tb/isr_exec_monitor.sv ***
module isr_exec_monitor #(
    parameter int PTR_W = isr_exec_pkg::PTR_W,
    parameter int PC_W  = isr_exec_pkg::PC_W
) (
    input wire logic                  MCLK,               // clock
    input wire logic                  SYS_RST,            // reset
    input wire logic [13:0]           INSN,               // word
    input wire logic                  INSN_VALID,         // word present
    input wire logic [7:0]            W_REG,              // working reg
    input wire logic [PC_W-1:0]       STACK_TOP,          // stack top
    input wire logic [PC_W-1:0]       PROGRAM_COUNTER,    // counter
    input wire logic                  STACK_POP,          // pop
    input wire logic                  GLOBAL_IRQ_ENABLE,  // enable
    input wire logic [7:0]            OPTION_REG,         // option
    input wire logic                  RESET_INSTR_FLAG_N, // flag
    input wire logic                  SW_RESET_REQ,       // reset req
    input wire isr_exec_pkg::mem_wr_s MEM_WR,             // write
    input wire logic [PTR_W-1:0]      PTR0,               // pointer 0
    input wire logic [PTR_W-1:0]      PTR1,               // pointer 1
    input wire logic                  BUSY                // busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    // ==========================================================
    // decode
    // ==========================================================
    wire logic             tk  = INSN_VALID && !BUSY;
    wire logic             st  = tk && INSN[13:3] == isr_exec_pkg::OP_STORE_MASK;
    wire logic             rel = tk && INSN[13:7] == isr_exec_pkg::OP_STORE_REL;
    wire logic             ret = tk && (INSN == isr_exec_pkg::OP_RETURN || INSN == isr_exec_pkg::OP_RETURN_FROM_IRQ);
    wire logic [PTR_W-1:0] sp  = INSN[2] ? PTR1 : PTR0;
    wire logic [PTR_W-1:0] rp  = INSN[6] ? PTR1 : PTR0;
    wire logic [PTR_W-1:0] ofs = PTR_W'(signed'(INSN[5:0]));
    store_data_a: assert property (st |=> MEM_WR.we && MEM_WR.data == $past(W_REG))
        else $error("store data wrong");
    pre_addr_a: assert property (st && !INSN[1] |=> MEM_WR.addr == PTR_W'($past(INSN[0]) ? $past(sp) - 1 : $past(sp) + 1))
        else $error("pre address wrong");
    post_addr_a: assert property (st && INSN[1] |=> MEM_WR.addr == $past(sp))
        else $error("post address wrong");
    ptr_step_a: assert property (st |=> ($past(INSN[2]) ? PTR1 : PTR0) == PTR_W'($past(INSN[0]) ? $past(sp) - 1 : $past(sp) + 1))
        else $error("pointer update wrong");
    rel_addr_a: assert property (rel |=> MEM_WR.addr == PTR_W'($past(rp) + $past(ofs)) && $stable(PTR0) && $stable(PTR1))
        else $error("offset store wrong");
    option_load_a: assert property (tk && INSN == isr_exec_pkg::OP_OPTION |=> OPTION_REG == $past(W_REG))
        else $error("option load wrong");
    sw_reset_a: assert property (tk && INSN == isr_exec_pkg::OP_RESET |=> SW_RESET_REQ && !RESET_INSTR_FLAG_N)
        else $error("soft reset wrong");
    irq_return_a: assert property (tk && INSN == isr_exec_pkg::OP_RETURN_FROM_IRQ |=> STACK_POP && GLOBAL_IRQ_ENABLE && PROGRAM_COUNTER == $past(STACK_TOP))
        else $error("irq return wrong");
    ret_two_cycles_a: assert property (ret |=> BUSY ##1 !BUSY && !STACK_POP && $stable(PROGRAM_COUNTER))
        else $error("return length wrong");
    sub_return_a: assert property (tk && INSN == isr_exec_pkg::OP_RETURN |=> STACK_POP && $stable(GLOBAL_IRQ_ENABLE) && PROGRAM_COUNTER == $past(STACK_TOP))
        else $error("return wrong");
    nop_step_a: assert property (tk && INSN == isr_exec_pkg::OP_NOP |=> PROGRAM_COUNTER == PC_W'($past(PROGRAM_COUNTER) + 1) && !MEM_WR.we && $stable(OPTION_REG))
        else $error("no-op wrong");
    cover property (st);
    cover property (rel);
    cover property (ret);
endmodule

bind indirect_store_and_return_exec isr_exec_monitor #(.PTR_W(PTR_W), .PC_W(PC_W)) u_mon (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .INSN(INSN), .INSN_VALID(INSN_VALID), .W_REG(W_REG), .STACK_TOP(STACK_TOP),
    .PROGRAM_COUNTER(PROGRAM_COUNTER), .STACK_POP(STACK_POP), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .OPTION_REG(OPTION_REG), .RESET_INSTR_FLAG_N(RESET_INSTR_FLAG_N), .SW_RESET_REQ(SW_RESET_REQ),
    .MEM_WR(MEM_WR), .PTR0(PTR0), .PTR1(PTR1), .BUSY(BUSY));

// *** tb/indirect_store_and_return_exec_tb.sv ***
module indirect_store_and_return_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  MCLK, SYS_RST, INSN_VALID, STACK_POP, GLOBAL_IRQ_ENABLE, RESET_INSTR_FLAG_N, SW_RESET_REQ, BUSY;
    logic [13:0]           INSN;
    logic [7:0]            W_REG, OPTION_REG;
    logic [14:0]           STACK_TOP, PROGRAM_COUNTER, pc;
    logic [15:0]           PTR0, PTR1, p[2], a;
    isr_exec_pkg::mem_wr_s MEM_WR;
    int                    err_count, compares;
    indirect_store_and_return_exec u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSN(INSN), .INSN_VALID(INSN_VALID),
        .W_REG(W_REG), .STACK_TOP(STACK_TOP), .PROGRAM_COUNTER(PROGRAM_COUNTER), .STACK_POP(STACK_POP),
        .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .OPTION_REG(OPTION_REG), .RESET_INSTR_FLAG_N(RESET_INSTR_FLAG_N),
        .SW_RESET_REQ(SW_RESET_REQ), .MEM_WR(MEM_WR), .PTR0(PTR0), .PTR1(PTR1), .BUSY(BUSY));
    // ==========================================================
    // helpers
    // ==========================================================
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task step(input logic [13:0] i, input logic [7:0] w);
        INSN = i;
        W_REG = w;
        INSN_VALID = 1'b1;
        @(posedge MCLK);
        #1;
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task t_store;
        p[0] = 16'h0000;
        p[1] = 16'h0000;
        for (int n = 0; n < 2; n++) begin
            for (int m = 3; m >= 0; m--) begin
                a = p[n];
                if (m < 2) a = (m == 0) ? a + 16'h0001 : a - 16'h0001;
                pc = PROGRAM_COUNTER;
                step({11'h003, 1'(n), 2'(m)}, 8'hA5);
                p[n] = m[0] ? p[n] - 16'h0001 : p[n] + 16'h0001;
                chk(MEM_WR.addr, a);
                chk({7'h00, MEM_WR.we, MEM_WR.data}, 16'h01A5);
                chk(PTR0, p[0]);
                chk(PTR1, p[1]);
                chk({1'b0, PROGRAM_COUNTER}, {1'b0, pc + 15'h0001});
            end
        end
        $display("store modes done");
    endtask
    task t_rel;
        step({7'h3F, 1'b1, 6'h20}, 8'h3C);
        chk(MEM_WR.addr, 16'hFFE0);
        chk(PTR1, 16'h0000);
        step({7'h3F, 1'b0, 6'h1F}, 8'h3C);
        chk(MEM_WR.addr, 16'h001F);
        chk(PTR0, 16'h0000);
        $display("offset store done");
    endtask
    task t_misc;
        chk({8'h00, OPTION_REG}, 16'h00FF);
        step(isr_exec_pkg::OP_OPTION, 8'h5A);
        chk({8'h00, OPTION_REG}, 16'h005A);
        pc = PROGRAM_COUNTER;
        step(isr_exec_pkg::OP_NOP, 8'hC3);
        chk({1'b0, PROGRAM_COUNTER}, {1'b0, pc + 15'h0001});
        chk({7'h00, MEM_WR.we, OPTION_REG}, 16'h005A);
        step(isr_exec_pkg::OP_RESET, 8'h00);
        chk({14'h0000, SW_RESET_REQ, RESET_INSTR_FLAG_N}, 16'h0002);
        INSN_VALID = 1'b0;
        @(posedge MCLK);
        #1;
        chk({15'h0000, SW_RESET_REQ}, 16'h0000);
        $display("option nop reset done");
    endtask
    task t_ret;
        for (int r = 0; r < 3; r++) begin
            STACK_TOP = 15'h1234 + 15'(r);
            INSN = (r == 1) ? isr_exec_pkg::OP_RETURN_FROM_IRQ : isr_exec_pkg::OP_RETURN;
            INSN_VALID = 1'b1;
            @(posedge MCLK);
            #1;
            INSN = isr_exec_pkg::OP_NOP;
            chk({1'b0, PROGRAM_COUNTER}, {1'b0, STACK_TOP});
            chk({13'h0000, STACK_POP, BUSY, GLOBAL_IRQ_ENABLE}, 16'h0006 + 16'(r != 0));
            @(posedge MCLK);
            #1;
            chk({1'b0, PROGRAM_COUNTER}, {1'b0, STACK_TOP});
            chk({14'h0000, STACK_POP, BUSY}, 16'h0000);
        end
        INSN_VALID = 1'b0;
        $display("returns done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end
    initial begin
        #20000;
        err_count++;
        stop_test;
    end
    initial begin
        {SYS_RST, INSN_VALID, INSN, W_REG, STACK_TOP} = {1'b1, 1'b0, 14'h0000, 8'h00, 15'h0000};
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge MCLK);
        #1;
        SYS_RST = 1'b0;
        t_store;
        t_rel;
        t_misc;
        t_ret;
        stop_test;
    end
endmodule
